// ===== dv/core_ack_model.sv
// Core sequencer model that vectors to the timer zero and one routines
module core_ack_model #(
    parameter ACK_PHASE = 4'h1
) (
    input wire clk_in, // System clock
    input wire ack_en_in, // Allow vectoring
    input wire [5:0] req_in, // Polled requests
    input wire [3:0] phase_in, // Machine cycle phase
    output reg t0_ack_out = 1'h0, // Vectored to timer zero
    output reg t1_ack_out = 1'h0 // Vectored to timer one
);
    // Acks timer zero and timer one at ACK_PHASE, both in the same cycle if both requested; timer two and serial left to software
    always @(negedge clk_in) begin
        t0_ack_out <= ack_en_in && req_in[1] && phase_in == ACK_PHASE;
        t1_ack_out <= ack_en_in && req_in[3] && phase_in == ACK_PHASE;
    end
endmodule // core_ack_model

// ===== dv/irq_pd_properties.sv
// Concurrent checks on the interrupt combiner and power-down wake ports
module irq_pd_properties #(
    parameter WAKE_CYCLES = 20
) (
    input logic clk_in, sys_rst_in, ext_irq_pin_a_in, ext_irq_pin_b_in, // Clock, reset, pins
    input logic wake_edge_select_in, uart_rx_flag_in, uart_tx_flag_in, spi_irq_gate_in, // Levels
    input logic pd_req_in, t2_ovf_clear_in, spi_done_clear_in, t0_overflow_flag_out, // Controls
    input logic t2_overflow_flag_out, t2_external_flag_out, spi_done_flag_out, // Flags
    input logic osc_run_out, core_halt_out, resume_out, resume_irq_out, // Power state
    input logic ale_out, prog_fetch_strobe_out, // Strobe pins
    input logic [7:0] irq_enable_reg_in, // Enable byte
    input logic [5:0] irq_request_out, // Polled requests
    input logic [3:0] phase_out // Phase index
);
    localparam int WAKE_MAX = WAKE_CYCLES + 4;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // Edge right after a poll while running
    sequence s_poll;
        $past(phase_out) == 4'hb && $past(osc_run_out);
    endsequence
    // Enabled pin b falls during power-down, delayed resume
    sequence s_pin_b_fall;
        !osc_run_out && !wake_edge_select_in && irq_enable_reg_in[7] && irq_enable_reg_in[2]
            && $fell(ext_irq_pin_b_in);
    endsequence
    a_t0_flag_phase: assert property ($rose(t0_overflow_flag_out) |-> $past(phase_out) == 4'h9)
        else $error("timer zero flag set off phase 9");
    a_t2_request_or: assert property ($past(phase_out) > 4'h3 && $past(osc_run_out)
        && $stable({t2_overflow_flag_out, t2_external_flag_out}) |-> irq_request_out[5] ==
        ($past(irq_enable_reg_in[7]) && $past(irq_enable_reg_in[5])
        && (t2_overflow_flag_out || t2_external_flag_out))) else $error("timer two request wrong");
    a_serial_request_or: assert property (s_poll |-> irq_request_out[4] ==
        ($past(irq_enable_reg_in[7]) && $past(irq_enable_reg_in[4]) && ($past(uart_rx_flag_in)
        || $past(uart_tx_flag_in) || ($past(spi_done_flag_out) && $past(spi_irq_gate_in)))))
        else $error("serial request wrong");
    a_global_gate_mask: assert property (s_poll ##0 !$past(irq_enable_reg_in[7])
        |-> irq_request_out == 6'h00) else $error("request with global gate off");
    a_pd_entry_pins: assert property (pd_req_in && osc_run_out && !core_halt_out
        |=> !osc_run_out && core_halt_out && !ale_out && !prog_fetch_strobe_out)
        else $error("power-down entry wrong");
    a_pd_state_kept: assert property (!osc_run_out ##1 !osc_run_out
        |-> $stable(phase_out) && $stable(t0_overflow_flag_out)) else $error("state moved in pd");
    a_rising_edge_wake: assert property (!osc_run_out && wake_edge_select_in
        && irq_enable_reg_in[7] && irq_enable_reg_in[0] && $rose(ext_irq_pin_a_in)
        |-> ##[1:2] resume_irq_out && resume_out) else $error("no resume on rising edge");
    a_delay_wake_bound: assert property (s_pin_b_fall |-> ##[1:WAKE_MAX] resume_out)
        else $error("no resume after wake delay");
    a_t2_flag_kept: assert property (t2_overflow_flag_out && !t2_ovf_clear_in
        |=> t2_overflow_flag_out) else $error("timer two flag lost");
    a_spi_flag_kept: assert property (spi_done_flag_out && !spi_done_clear_in
        |=> spi_done_flag_out) else $error("spi done flag lost");
endmodule // irq_pd_properties

bind irq_and_powerdown_wake irq_pd_properties #(.WAKE_CYCLES(WAKE_CYCLES)) irq_pd_properties_i (.*);

// ===== dv/tb.sv
// Self-checking bench for the interrupt combiner and power-down wake block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam WAKE = 20;
    reg clk_in = 1'h0, sys_rst_in = 1'h1, ext_irq_pin_a_in = 1'h1, ext_irq_pin_b_in = 1'h1;
    reg [7:0] irq_enable_reg_in = 8'h00, seed = 8'h4c;
    reg ext_a_flag_in = 1'h0, ext_b_flag_in = 1'h0, t0_overflow_in = 1'h0, t1_overflow_in = 1'h0;
    reg t2_overflow_in = 1'h0, t2_external_in = 1'h0, t0_clear_in = 1'h0, t1_clear_in = 1'h0;
    reg t2_ovf_clear_in = 1'h0, t2_ext_clear_in = 1'h0, uart_rx_flag_in = 1'h0, ack_en = 1'h0;
    reg uart_tx_flag_in = 1'h0, spi_xfer_done_in = 1'h0, spi_done_clear_in = 1'h0;
    reg spi_irq_gate_in = 1'h0, wake_edge_select_in = 1'h0, ext_prog_mem_in = 1'h0;
    reg idle_req_in = 1'h0, pd_req_in = 1'h0, idle_exit_in = 1'h0;
    wire t0_vector_ack_in, t1_vector_ack_in, t0_overflow_flag_out, t1_overflow_flag_out;
    wire t2_overflow_flag_out, t2_external_flag_out, spi_done_flag_out, osc_run_out;
    wire core_halt_out, resume_out, resume_irq_out, ale_out, prog_fetch_strobe_out;
    wire port0_float_out, port2_addr_out;
    wire [5:0] irq_request_out;
    wire [3:0] phase_out;
    // Mode pin status: osc, halt, ale, strobe, port zero float, port two address
    wire [5:0] pins = {osc_run_out, core_halt_out, ale_out, prog_fetch_strobe_out, port0_float_out,
        port2_addr_out};
    integer error_cnt = 0, comparisons = 0, k;
    reg [5:0] rq[$];
    reg [1:0] wq[$];
    reg [5:0] pq[$];
    reg [5:0] last_pins_r = 6'h2c;
    irq_and_powerdown_wake #(.WAKE_CYCLES(WAKE)) irq_and_powerdown_wake_i (.*);
    core_ack_model core_ack_model_i (.clk_in(clk_in), .ack_en_in(ack_en), .req_in(irq_request_out),
        .phase_in(phase_out), .t0_ack_out(t0_vector_ack_in), .t1_ack_out(t1_vector_ack_in));
    always #25 clk_in = ~clk_in;
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic pulse(ref reg s);
        s = 1'h1;
        @(negedge clk_in);
        s = 1'h0;
    endtask
    // Note the expected request word for the coming poll
    task poll(input [5:0] src);
        integer n;
        @(negedge clk_in);
        for (n = 0; n < 30 && phase_out !== 4'hb; n++) @(negedge clk_in);
        rq.push_back(irq_enable_reg_in[7] ? src & irq_enable_reg_in[5:0] : 6'h00);
        repeat (2) @(negedge clk_in);
    endtask
    task check(input ok, input [5:0] exp, input [5:0] got);
        comparisons++;
        if (!ok) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_req(input [5:0] exp, input [5:0] got);
        check(got === exp, exp, got);
    endtask
    task cmp_wake(input [1:0] exp, input [1:0] got);
        check(got === exp, {4'h0, exp}, {4'h0, got});
    endtask
    task cmp_pins(input [5:0] exp, input [5:0] got);
        check(got === exp, exp, got);
    endtask
    task tally_and_finish;
        if (rq.size() + wq.size() + pq.size() != 0) begin
            error_cnt++;
            $display("Error %0t: expected results never seen", $time);
        end
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Output watcher: match results against the oldest note
    always @(negedge clk_in) begin
        if (phase_out === 4'h0 && osc_run_out === 1'h1 && rq.size() > 0)
            cmp_req(rq.pop_front(), irq_request_out);
        if ((resume_out | resume_irq_out) === 1'h1)
            cmp_wake(wq.size() > 0 ? wq.pop_front() : 2'h0, {resume_out, resume_irq_out});
        if (pins !== last_pins_r) begin
            cmp_pins(pq.size() > 0 ? pq.pop_front() : last_pins_r, pins);
            last_pins_r <= pins;
        end
    end
    // Watchdog
    initial begin
        #250000;
        error_cnt++;
        $display("Error %0t: timeout", $time);
        tally_and_finish;
    end
    // Main sequence
    initial begin
        repeat (12) @(negedge clk_in);
        sys_rst_in = 1'h0;
        {t0_overflow_in, t1_overflow_in, t2_overflow_in, t2_external_in, spi_xfer_done_in} = 5'h1f;
        @(negedge clk_in);
        {t0_overflow_in, t1_overflow_in, t2_overflow_in, t2_external_in, spi_xfer_done_in} = 5'h00;
        repeat (12) @(negedge clk_in);
        for (k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            irq_enable_reg_in = seed & 8'hbf;
            seed = lfsr(seed);
            {ext_a_flag_in, ext_b_flag_in, uart_rx_flag_in, uart_tx_flag_in, spi_irq_gate_in} = seed[4:0];
            poll({1'h1, uart_rx_flag_in | uart_tx_flag_in | spi_irq_gate_in, 1'h1, ext_b_flag_in,
                1'h1, ext_a_flag_in});
        end
        {uart_rx_flag_in, uart_tx_flag_in, spi_irq_gate_in} = 3'h1;
        irq_enable_reg_in = 8'hb0;
        pulse(t2_ovf_clear_in);
        poll(6'h30);
        pulse(t2_ext_clear_in);
        pulse(spi_done_clear_in);
        poll(6'h00);
        irq_enable_reg_in = 8'h8a;
        ack_en = 1'h1;
        repeat (30) @(negedge clk_in);
        ack_en = 1'h0;
        poll(6'h00);
        pulse(t0_overflow_in);
        poll(6'h02);
        pulse(t0_clear_in);
        pulse(t1_clear_in);
        poll(6'h00);
        repeat (80) @(negedge clk_in);
        irq_enable_reg_in = 8'h81;
        wake_edge_select_in = 1'h1;
        pq.push_back(6'h10);
        pq.push_back(6'h2c);
        pulse(pd_req_in);
        ext_irq_pin_a_in = 1'h0;
        wq.push_back(2'h3);
        repeat (10) @(negedge clk_in);
        ext_irq_pin_a_in = 1'h1;
        for (k = 0; k < 10 && wq.size() > 0; k++) @(negedge clk_in);
        // Idle with external program memory; timer flags keep running
        ext_prog_mem_in = 1'h1;
        irq_enable_reg_in = 8'h88;
        pq.push_back(6'h3f);
        pulse(idle_req_in);
        pulse(t1_overflow_in);
        poll(6'h08);
        pq.push_back(6'h2c);
        wq.push_back(2'h2);
        pulse(idle_exit_in);
        pulse(t1_clear_in);
        repeat (80) @(negedge clk_in);
        irq_enable_reg_in = 8'h84;
        wake_edge_select_in = 1'h0;
        pq.push_back(6'h12);
        pq.push_back(6'h2c);
        pulse(pd_req_in);
        ext_irq_pin_b_in = 1'h0;
        wq.push_back(2'h3);
        repeat (WAKE + 8) @(negedge clk_in);
        ext_irq_pin_b_in = 1'h1;
        // Flags set, then a reset taken in power-down must clear them
        irq_enable_reg_in = 8'hb0;
        pulse(t2_external_in);
        pulse(spi_xfer_done_in);
        poll(6'h30);
        repeat (80) @(negedge clk_in);
        pq.push_back(6'h12);
        pq.push_back(6'h2c);
        pulse(pd_req_in);
        repeat (4) @(negedge clk_in);
        sys_rst_in = 1'h1;
        repeat (3) @(negedge clk_in);
        sys_rst_in = 1'h0;
        repeat (2) @(negedge clk_in);
        poll(6'h00);
        tally_and_finish;
    end
endmodule // tb

// ===== hdl/irq_and_powerdown_wake.v
// Interrupt combiner with idle and power-down pin and wake control
`include "irq_pd_defs.vh"

// Operation
// - Six vectors: two pins, three timers, serial
// - Per-source enables plus global gate
// - Timer two request is overflow OR external
// - Serial request: rx, tx, gated SPI done
// - Vectoring leaves serial flags unchanged
// - Timers zero/one flags at S5P2, polled next
// - Idle/power-down strobe and port pin states
// - Power-down stops oscillator after last instruction
// - RAM and registers retained in power-down
// - Exit by reset or enabled external interrupt
// - Wake edge select: rising edge or delay
// - SPI done counts with SPI and serial enables
module irq_and_powerdown_wake #(
    parameter WAKE_CYCLES = `WAKE_DELAY_CYC
) (
    input wire clk_in, // System clock
    input wire sys_rst_in, // Synchronous reset, active high
    input wire [7:0] irq_enable_reg_in, // Enable byte from core
    input wire ext_irq_pin_a_in, // External interrupt pin a, low active
    input wire ext_irq_pin_b_in, // External interrupt pin b, low active
    input wire ext_a_flag_in, // Pin a flag from edge/level logic
    input wire ext_b_flag_in, // Pin b flag from edge/level logic
    input wire t0_overflow_in, // Timer zero overflow event
    input wire t1_overflow_in, // Timer one overflow event
    input wire t2_overflow_in, // Timer two overflow event
    input wire t2_external_in, // Timer two external event
    input wire t0_clear_in, // Software clear, timer zero flag
    input wire t1_clear_in, // Software clear, timer one flag
    input wire t0_vector_ack_in, // Core vectored to timer zero
    input wire t1_vector_ack_in, // Core vectored to timer one
    input wire t2_ovf_clear_in, // Software clear, timer two overflow
    input wire t2_ext_clear_in, // Software clear, timer two external
    input wire uart_rx_flag_in, // UART receive flag
    input wire uart_tx_flag_in, // UART transmit flag
    input wire spi_xfer_done_in, // SPI transfer finished pulse
    input wire spi_done_clear_in, // Software clear of SPI done
    input wire spi_irq_gate_in, // SPI interrupt enable
    input wire wake_edge_select_in, // 1: resume on rising pin edge
    input wire ext_prog_mem_in, // External program memory in use
    input wire idle_req_in, // Core requests idle
    input wire pd_req_in, // Core requests power-down
    input wire idle_exit_in, // Core leaves idle
    output reg [5:0] irq_request_out, // Polled requests per vector
    output reg t0_overflow_flag_out, // Timer zero flag
    output reg t1_overflow_flag_out, // Timer one flag
    output reg t2_overflow_flag_out, // Timer two overflow flag
    output reg t2_external_flag_out, // Timer two external flag
    output reg spi_done_flag_out, // SPI done flag
    output reg [3:0] phase_out, // Machine cycle phase index
    output reg osc_run_out, // Oscillator enable
    output reg core_halt_out, // Core halted, registers held
    output reg resume_out, // Pulse: resume execution
    output reg resume_irq_out, // Pulse: resume into interrupt
    output reg ale_out, // Address latch enable pin level
    output reg prog_fetch_strobe_out, // Program fetch strobe pin level
    output reg port0_float_out, // Port zero released
    output reg port2_addr_out // Port two drives address
);
    localparam ST_RUN = 2'h0;
    localparam ST_IDLE = 2'h1;
    localparam ST_PD = 2'h2;
    localparam ST_WAIT = 2'h3;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg pin_a_d_r;
    reg pin_b_d_r;
    reg t0_pend_r;
    reg t1_pend_r;
    reg [5:0] raw_req;
    wire [7:0] en = irq_enable_reg_in;
    wire pin_low = ~ext_irq_pin_a_in | ~ext_irq_pin_b_in;
    wire wake_en = en[`EN_BIT_GLOBAL] &
        ((~ext_irq_pin_a_in & en[`EN_BIT_EXT_A]) | (~ext_irq_pin_b_in & en[`EN_BIT_EXT_B]));
    wire fall = (pin_a_d_r & ~ext_irq_pin_a_in & en[`EN_BIT_EXT_A]) |
        (pin_b_d_r & ~ext_irq_pin_b_in & en[`EN_BIT_EXT_B]);
    wire rise = (~pin_a_d_r & ext_irq_pin_a_in) | (~pin_b_d_r & ext_irq_pin_b_in);
    wire delay_done;

    // Machine cycle phase counter
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            phase_out <= 4'h0;
        end else if (osc_run_out) begin
            phase_out <= (phase_out == `PH_LAST) ? 4'h0 : phase_out + 4'h1;
        end
    end

    // Timer flags; set beats clear, zero/one latched at S5P2, timer two and SPI done on the event
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            t0_pend_r <= 1'b0;
            t1_pend_r <= 1'b0;
            t0_overflow_flag_out <= 1'b0;
            t1_overflow_flag_out <= 1'b0;
            t2_overflow_flag_out <= 1'b0;
            t2_external_flag_out <= 1'b0;
            spi_done_flag_out <= 1'b0;
        end else if (!core_halt_out || state_r == ST_IDLE) begin
            t0_pend_r <= (t0_pend_r | t0_overflow_in) & ~(phase_out == `PH_S5P2);
            t1_pend_r <= (t1_pend_r | t1_overflow_in) & ~(phase_out == `PH_S5P2);
            if (phase_out == `PH_S5P2 && (t0_pend_r || t0_overflow_in))
                t0_overflow_flag_out <= 1'b1;
            else if (t0_clear_in || t0_vector_ack_in)
                t0_overflow_flag_out <= 1'b0;
            if (phase_out == `PH_S5P2 && (t1_pend_r || t1_overflow_in))
                t1_overflow_flag_out <= 1'b1;
            else if (t1_clear_in || t1_vector_ack_in)
                t1_overflow_flag_out <= 1'b0;
            // Timer two flags cleared only by software
            if (t2_overflow_in)
                t2_overflow_flag_out <= 1'b1;
            else if (t2_ovf_clear_in)
                t2_overflow_flag_out <= 1'b0;
            if (t2_external_in)
                t2_external_flag_out <= 1'b1;
            else if (t2_ext_clear_in)
                t2_external_flag_out <= 1'b0;
            if (spi_xfer_done_in)
                spi_done_flag_out <= 1'b1;
            else if (spi_done_clear_in)
                spi_done_flag_out <= 1'b0;
        end
    end

    // Gated request terms per vector
    always @* begin
        raw_req = 6'h00;
        raw_req[`VEC_EXT_A] = ext_a_flag_in & en[`EN_BIT_EXT_A];
        raw_req[`VEC_T0] = t0_overflow_flag_out & en[`EN_BIT_T0];
        raw_req[`VEC_EXT_B] = ext_b_flag_in & en[`EN_BIT_EXT_B];
        raw_req[`VEC_T1] = t1_overflow_flag_out & en[`EN_BIT_T1];
        raw_req[`VEC_SER] = (uart_rx_flag_in | uart_tx_flag_in |
            (spi_done_flag_out & spi_irq_gate_in)) & en[`EN_BIT_SER];
        raw_req[`VEC_T2] = (t2_overflow_flag_out | t2_external_flag_out) &
            en[`EN_BIT_T2];
        if (!en[`EN_BIT_GLOBAL])
            raw_req = 6'h00;
    end

    // Poll at end of machine cycle; timer two also sampled each phase after S2P2, cleared before
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            irq_request_out <= 6'h00;
        end else if (phase_out == `PH_LAST) begin
            irq_request_out <= raw_req;
        end else begin
            irq_request_out[`VEC_T2] <= raw_req[`VEC_T2] & (phase_out > `PH_S2P2);
        end
    end

    // Pin history for wake edges
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            pin_a_d_r <= 1'b1;
            pin_b_d_r <= 1'b1;
        end else begin
            pin_a_d_r <= ext_irq_pin_a_in;
            pin_b_d_r <= ext_irq_pin_b_in;
        end
    end

    wake_timer #(
        .COUNT(WAKE_CYCLES)
    ) u_wake (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(state_r == ST_PD && fall && en[`EN_BIT_GLOBAL] && !wake_edge_select_in),
        .abort_in(state_r == ST_RUN),
        .done_out(delay_done)
    );

    // Mode sequencing
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (pd_req_in)
                    state_nxt = ST_PD;
                else if (idle_req_in)
                    state_nxt = ST_IDLE;
            end
            ST_IDLE: begin
                if (idle_exit_in)
                    state_nxt = ST_RUN;
            end
            ST_PD: begin
                if (wake_en)
                    state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                if (wake_edge_select_in ? rise : delay_done)
                    state_nxt = ST_RUN;
                else if (!pin_low && !wake_edge_select_in && !delay_done)
                    state_nxt = ST_WAIT;
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    // State register and pin status outputs
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_r <= ST_RUN;
            osc_run_out <= 1'b1;
            core_halt_out <= 1'b0;
            resume_out <= 1'b0;
            resume_irq_out <= 1'b0;
            ale_out <= 1'b1;
            prog_fetch_strobe_out <= 1'b1;
            port0_float_out <= 1'b0;
            port2_addr_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            osc_run_out <= (state_nxt == ST_RUN) || (state_nxt == ST_IDLE);
            core_halt_out <= (state_nxt != ST_RUN);
            resume_out <= (state_r != ST_RUN) && (state_nxt == ST_RUN);
            resume_irq_out <= (state_r == ST_WAIT) && (state_nxt == ST_RUN);
            ale_out <= ~(state_nxt == ST_PD || state_nxt == ST_WAIT);
            prog_fetch_strobe_out <= ~(state_nxt == ST_PD || state_nxt == ST_WAIT);
            port0_float_out <= ext_prog_mem_in && (state_nxt != ST_RUN);
            port2_addr_out <= ext_prog_mem_in && (state_nxt == ST_IDLE);
        end
    end
endmodule // irq_and_powerdown_wake

// ===== hdl/irq_pd_defs.vh
// Constants for the interrupt combiner and power-down wake block
`ifndef IRQ_PD_DEFS_VH
`define IRQ_PD_DEFS_VH
// Enable byte layout
`define EN_BIT_EXT_A 0
`define EN_BIT_T0 1
`define EN_BIT_EXT_B 2
`define EN_BIT_T1 3
`define EN_BIT_SER 4
`define EN_BIT_T2 5
`define EN_BIT_RSVD 6
`define EN_BIT_GLOBAL 7
`define EN_RESET 8'h00
// Vector request layout
`define VEC_EXT_A 0
`define VEC_T0 1
`define VEC_EXT_B 2
`define VEC_T1 3
`define VEC_SER 4
`define VEC_T2 5
`define NUM_VEC 6
// Machine cycle: 6 states of 2 phases, one clock each
`define PHASES_PER_CYCLE 12
`define PH_S2P2 4'h3
`define PH_S5P2 4'h9
`define PH_LAST 4'hb
// Wake delay
`define WAKE_DELAY_US 2000
`define CLK_MHZ 20
`define WAKE_DELAY_CYC (`WAKE_DELAY_US * `CLK_MHZ)
`endif

// ===== hdl/wake_timer.v
// Self-timed wake delay counter, runs on its own count
`include "irq_pd_defs.vh"
module wake_timer #(
    parameter COUNT = `WAKE_DELAY_CYC
) (
    input wire clk_in, // System clock
    input wire sys_rst_in, // Synchronous reset, active high
    input wire start_in, // Start pulse
    input wire abort_in, // Stop and clear
    output reg done_out // One-cycle pulse at expiry
);
    reg [19:0] cnt_r;
    reg run_r;

    // Count down from start to expiry
    always @(posedge clk_in) begin
        if (sys_rst_in || abort_in) begin
            cnt_r <= 20'h00000;
            run_r <= 1'b0;
            done_out <= 1'b0;
        end else if (start_in) begin
            cnt_r <= COUNT[19:0] - 20'h00001;
            run_r <= 1'b1;
            done_out <= 1'b0;
        end else if (run_r) begin
            done_out <= (cnt_r == 20'h00000);
            run_r <= (cnt_r != 20'h00000);
            cnt_r <= cnt_r - 20'h00001;
        end else begin
            done_out <= 1'b0;
        end
    end
endmodule // wake_timer
